//--- hdl/fpcm_top.sv
`timescale 1ns/100ps
// Summary of operation
// - Inexact results round by the selected mode; nearest-even stays within half a unit in last place.
// - The rounding mode comes from a control field, not hardwired.
// - Half denormal inputs widen to normal singles, computed in 32 bits; compares and min/max rank them as zero.
// - Denormal outputs after a format conversion are kept, never flushed.
// - Mixed-width operations equal the sequence of their separate steps.
// - A NaN operand gives a NaN result except in min/max and compares; a raw move copies bits unchanged.
// - x*1 and x+0 return x, and -0 + +0 gives +0 except when rounding down.
// - Fused ops may return the true result or signed infinity on overflow.
// - The accumulator is wider than single, so results may differ.
// - Division is a rounded reciprocal followed by a rounded multiply.
// - Min or max with exactly one NaN returns the other operand.
// - Min or max with two NaNs returns source one.
// - Min and max use conditional select and never write the flag.
// - Aware compares: true if src1 is NaN, else false if src0 is NaN.
// - Aware less-than: denormals equal zeros, -0 below +0, others ordinary.
// - Aware greater-or-equal is the complement of less-than for non-NaNs.
module fpcm_top (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  // issue side
  input  wire logic                  issue_valid,
  input  wire fpcm_pkg::fpcm_op_type issue_op,
  input  wire fpcm_pkg::fpcm_rm_type rounding_mode,
  input  wire logic [31:0]           src0_data,
  input  wire logic [31:0]           src1_data,
  input  wire logic [31:0]           src2_data,
  input  wire logic                  src0_half,
  input  wire logic                  src1_half,
  input  wire logic                  src2_half,
  output logic                       issue_ready,
  // result side
  output logic                       result_valid,
  output logic [31:0]                result_data,
  output logic                       flag_data,
  output logic                       flag_write
);
  import fpcm_pkg::*;

  fpcm_regs_type st_q;
  fpcm_regs_type st_d;
  fpcm_num_type  n0;
  fpcm_num_type  n1;
  fpcm_num_type  n2;

  fpcm_opnd_if u0 ();
  fpcm_opnd_if u1 ();
  fpcm_opnd_if u2 ();

  fpcm_unpack unp0 (.opnd(u0));
  fpcm_unpack unp1 (.opnd(u1));
  fpcm_unpack unp2 (.opnd(u2));

  // operands are unpacked from the latched words, so they hold steady
  // through multi-cycle operations
  assign u0.word = st_q.w0;
  assign u1.word = st_q.w1;
  assign u2.word = st_q.w2;
  assign u0.half = st_q.h0;
  assign u1.half = st_q.h1;
  assign u2.half = st_q.h2;
  assign n0 = {u0.nan, u0.inf, u0.zero, u0.sign, u0.exp, u0.sig, 3'h0};
  assign n1 = {u1.nan, u1.inf, u1.zero, u1.sign, u1.exp, u1.sig, 3'h0};
  assign n2 = {u2.nan, u2.inf, u2.zero, u2.sign, u2.exp, u2.sig, 3'h0};

  // bring the leading one of v to the top; bit 49 weighs 2^(e-bias)
  function automatic fpcm_num_type norm(input logic s,
                                        input logic signed [11:0] e,
                                        input logic [49:0] v);
    fpcm_num_type r;
    logic [5:0]   lz;
    logic [49:0]  vs;
    r = '0;
    lz = 6'h00;
    for (int i = 0; i < 50; i++) begin
      if (v[i]) begin
        lz = 6'(49 - i);
      end
    end
    vs = v << lz;
    r.sign = s;
    r.zero = (v == 50'h0);
    r.exp = e - 12'(lz);
    r.sig = {vs[49:24], |vs[23:0]};
    return r;
  endfunction

  // product cut to 26 bits and a sticky bit, left unrounded for a fused add
  function automatic fpcm_num_type mul_num(input fpcm_num_type a,
                                           input fpcm_num_type b);
    fpcm_num_type r;
    logic [47:0]  p;
    r = '0;
    r.sign = a.sign ^ b.sign;
    p = a.sig[26:3] * b.sig[26:3];
    if (a.nan | b.nan | (a.inf & b.zero) | (a.zero & b.inf)) begin
      r.nan = 1'b1;
    end else if (a.inf | b.inf) begin
      r.inf = 1'b1;
    end else if (a.zero | b.zero) begin
      r.zero = 1'b1;
    end else begin
      // wide exponent: an oversized intermediate is not yet infinity
      r = norm(r.sign, a.exp + b.exp - MUL_EXP_ADJ, {p, 2'h0});
    end
    return r;
  endfunction

  // magnitude add or subtract with a sticky jam on the aligned operand
  function automatic fpcm_num_type add_num(input fpcm_num_type a,
                                           input fpcm_num_type b,
                                           input fpcm_rm_type rm);
    fpcm_num_type r;
    fpcm_num_type bg;
    fpcm_num_type sm;
    logic [11:0]  d;
    logic [49:0]  vb;
    logic [49:0]  vsm;
    logic [49:0]  vsh;
    logic [49:0]  sum;
    r = '0;
    bg = a;
    sm = b;
    if ((b.exp > a.exp) | ((b.exp == a.exp) & (b.sig > a.sig))) begin
      bg = b;
      sm = a;
    end
    d = bg.exp - sm.exp;
    vb = {1'b0, bg.sig, 22'h0};
    vsm = {1'b0, sm.sig, 22'h0};
    vsh = vsm >> d;
    if (d > 12'h031) begin
      vsh = 50'h1;
    end else if ((vsh << d) != vsm) begin
      vsh[0] = 1'b1;
    end
    sum = (a.sign == b.sign) ? vb + vsh : vb - vsh;
    if (a.nan | b.nan | (a.inf & b.inf & (a.sign != b.sign))) begin
      r.nan = 1'b1;
    end else if (a.inf) begin
      r = a;
    end else if (b.inf) begin
      r = b;
    end else if (a.zero & b.zero) begin
      r = a;
      // -0 + +0 is +0 except when rounding downward
      r.sign = (a.sign & b.sign) | ((a.sign | b.sign) & (rm == RM_DOWN));
    end else if (a.zero) begin
      r = b;
    end else if (b.zero) begin
      r = a;
    end else if (sum == 50'h0) begin
      r.zero = 1'b1;
      r.sign = (rm == RM_DOWN);
    end else begin
      r = norm(bg.sign, bg.exp + 12'h001, sum);
    end
    return r;
  endfunction

  // round to single; exponents at or below zero shift into a denormal
  // that is kept as it is, never flushed
  function automatic logic [31:0] round_pack(input fpcm_num_type n,
                                             input fpcm_rm_type rm);
    logic [26:0] sg;
    logic [11:0] sh;
    logic [7:0]  eb;
    logic [24:0] m;
    logic [31:0] mag;
    logic        inc;
    logic        ovf;
    logic        to_max;
    logic [31:0] w;
    sg = n.sig;
    eb = 8'(n.exp - 12'h001);
    sh = 12'h001 - n.exp;
    if (n.exp[11] | (n.exp == 12'h000)) begin
      eb = 8'h00;
      if (sh > 12'h01A) begin
        sg = {26'h0, |n.sig};
      end else begin
        sg = (n.sig >> sh) | {26'h0, ((n.sig >> sh) << sh) != n.sig};
      end
    end
    case (rm)
      RM_NEAR_EVEN: inc = sg[2] & (sg[1] | sg[0] | sg[3]);
      RM_UP:        inc = ~n.sign & (|sg[2:0]);
      RM_DOWN:      inc = n.sign & (|sg[2:0]);
      default:      inc = 1'b0;
    endcase
    m = {1'b0, sg[26:3]} + {24'h0, inc};
    // the hidden one adds into the exponent field, so a mantissa carry
    // or a denormal rounding up to fmin needs no extra case
    mag = {1'b0, eb, 23'h0} + {7'h00, m};
    ovf = mag[31] | (mag[30:23] == EXP_ALL_ONES)
        | (~n.exp[11] & (n.exp > EXP_TOP_NORM));
    to_max = (rm == RM_ZERO) | ((rm == RM_UP) & n.sign)
           | ((rm == RM_DOWN) & ~n.sign);
    if (n.nan) begin
      w = QNAN_WORD;
    end else if (n.inf) begin
      w = {n.sign, MAG_INF};
    end else if (n.zero) begin
      w = {n.sign, 31'h0};
    end else if (ovf) begin
      w = {n.sign, to_max ? MAG_FMAX : MAG_INF};
    end else begin
      w = {n.sign, mag[30:0]};
    end
    return w;
  endfunction

  // ordered less-than with denormals taken as zero but -0 below +0
  function automatic logic lt_rank(input logic sa,
                                   input logic sb,
                                   input logic fa,
                                   input logic fb,
                                   input logic za,
                                   input logic zb,
                                   input logic [35:0] ka,
                                   input logic [35:0] kb);
    logic r;
    if (fa & fb) begin
      r = za & zb & sa & ~sb;
    end else if (sa != sb) begin
      r = sa;
    end else begin
      r = sa ? (ka > kb) : (ka < kb);
    end
    return r;
  endfunction

  logic         flush0;
  logic         flush1;
  logic [35:0]  key0;
  logic [35:0]  key1;
  logic         lt_raw;
  logic         cmp_lt;
  logic         cmp_ge;
  logic         pick0;
  logic         fin;
  logic [31:0]  sel_word;
  fpcm_num_type rn;
  fpcm_num_type sum_n;
  logic [31:0]  rw;

  // compare network: one flag per channel, also the min/max select
  always_comb begin
    flush0 = u0.zero | u0.denorm;
    flush1 = u1.zero | u1.denorm;
    key0 = flush0 ? 36'h0 : {u0.exp, u0.sig};
    key1 = flush1 ? 36'h0 : {u1.exp, u1.sig};
    lt_raw = lt_rank(u0.sign, u1.sign, flush0, flush1, u0.zero, u1.zero,
                     key0, key1);
    cmp_lt = u1.nan | (~u0.nan & lt_raw);
    cmp_ge = u1.nan | (~u0.nan & ~lt_raw);
    // two NaNs fall through to source one
    pick0 = ~(u0.nan & u1.nan)
          & ((st_q.op == OP_MIN) ? cmp_lt : cmp_ge);
  end

  // next-state logic: one registered copy of the whole block state
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.flag_we = 1'b0;
    fin = 1'b0;
    rn = '0;
    sum_n = '0;
    rw = 32'h0;
    sel_word = 32'h0;
    case (st_q.state)
      ST_IDLE: begin
        if (issue_valid) begin
          st_d.ready = 1'b0;
          st_d.op = issue_op;
          st_d.rm = rounding_mode;
          st_d.w0 = src0_data;
          st_d.w1 = src1_data;
          st_d.w2 = src2_data;
          st_d.h0 = src0_half;
          st_d.h1 = src1_half;
          st_d.h2 = src2_half;
          st_d.cnt = 5'h00;
          st_d.rem = RCP_NUMER;
          st_d.quo = 28'h0;
          if ((issue_op == OP_RCP) | (issue_op == OP_DIV)) begin
            st_d.state = ST_RCP;
          end else begin
            st_d.state = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        fin = 1'b1;
        case (st_q.op)
          OP_MOV: begin
            st_d.result = st_q.w0;
          end
          OP_ADD: begin
            st_d.result = round_pack(add_num(n0, n1, st_q.rm), st_q.rm);
          end
          OP_MUL: begin
            st_d.result = round_pack(mul_num(n0, n1), st_q.rm);
          end
          OP_MAC, OP_MACA: begin
            fin = 1'b0;
            st_d.t = mul_num(n0, n1);
            st_d.state = ST_ADD;
          end
          OP_ACCW: begin
            st_d.acc = n0;
            st_d.result = round_pack(n0, st_q.rm);
          end
          OP_MIN, OP_MAX: begin
            // plain select, flag left alone
            if (pick0) begin
              rn = n0;
              sel_word = st_q.w0;
            end else begin
              rn = n1;
              sel_word = st_q.w1;
            end
            if (rn.nan & ~(pick0 ? st_q.h0 : st_q.h1)) begin
              st_d.result = sel_word;
            end else begin
              st_d.result = round_pack(rn, st_q.rm);
            end
          end
          OP_CMP_LT, OP_CMP_GE: begin
            st_d.flag = (st_q.op == OP_CMP_LT) ? cmp_lt : cmp_ge;
            st_d.flag_we = 1'b1;
            st_d.result = {32{st_d.flag}};
          end
          default: begin
            st_d.result = QNAN_WORD;
          end
        endcase
      end
      ST_ADD: begin
        // one rounding at the end; the accumulator keeps the wide sum
        sum_n = add_num(st_q.t, (st_q.op == OP_MACA) ? st_q.acc : n2,
                        st_q.rm);
        if (st_q.op == OP_MACA) begin
          st_d.acc = sum_n;
        end
        st_d.result = round_pack(sum_n, st_q.rm);
        fin = 1'b1;
      end
      ST_RCP: begin
        if (st_q.cnt != RCP_ITER) begin
          // restoring division of 1.0 by the divisor, one bit a cycle
          if (st_q.rem >= {1'b0, u1.sig}) begin
            st_d.rem = (st_q.rem - {1'b0, u1.sig}) << 1;
            st_d.quo = {st_q.quo[26:0], 1'b1};
          end else begin
            st_d.rem = st_q.rem << 1;
            st_d.quo = {st_q.quo[26:0], 1'b0};
          end
          st_d.cnt = st_q.cnt + 5'h01;
        end else begin
          rn = norm(u1.sign, RCP_EXP_BASE - u1.exp,
                    {st_q.quo, 21'h0, |st_q.rem});
          rn.nan = u1.nan;
          rn.zero = u1.inf;
          rn.inf = u1.zero;
          rw = round_pack(rn, st_q.rm);
          if (st_q.op == OP_DIV) begin
            // second step multiplies by the rounded reciprocal
            st_d.w1 = rw;
            st_d.h1 = 1'b0;
            st_d.op = OP_MUL;
            st_d.state = ST_EXEC;
          end else begin
            st_d.result = rw;
            fin = 1'b1;
          end
        end
      end
      default: begin
        st_d.state = ST_IDLE;
        st_d.ready = 1'b1;
      end
    endcase
    if (fin) begin
      st_d.done = 1'b1;
      st_d.ready = 1'b1;
      st_d.state = ST_IDLE;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= REGS_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state flops
  assign issue_ready  = st_q.ready;
  assign result_valid = st_q.done;
  assign result_data  = st_q.result;
  assign flag_data    = st_q.flag;
  assign flag_write   = st_q.flag_we;

endmodule

//--- hdl/fpcm_pkg.sv
package fpcm_pkg;

  // format constants
  localparam logic [11:0] SGL_BIAS     = 12'h07F;
  localparam logic [11:0] HLF_REBIAS   = 12'h070;
  localparam logic [11:0] EXP_TOP_NORM = 12'h0FE;
  localparam logic [11:0] MUL_EXP_ADJ  = 12'h07E;
  localparam logic [11:0] RCP_EXP_BASE = 12'h0FE;
  localparam logic [7:0]  EXP_ALL_ONES = 8'hFF;
  localparam logic [11:0] EXP_SPECIAL  = 12'h0FF;
  localparam logic [31:0] QNAN_WORD    = 32'h7FC0_0000;
  localparam logic [30:0] MAG_INF      = 31'h7F80_0000;
  localparam logic [30:0] MAG_FMAX     = 31'h7F7F_FFFF;
  localparam int unsigned SGN_POS      = 31;
  localparam int unsigned HLF_SGN_POS  = 15;

  // reciprocal iteration: quotient bits and the numerator 1.0
  localparam logic [4:0]  RCP_ITER     = 5'h1C;
  localparam logic [24:0] RCP_NUMER    = 25'h080_0000;

  typedef enum logic [1:0] {
    RM_NEAR_EVEN = 2'h0,
    RM_UP        = 2'h1,
    RM_DOWN      = 2'h2,
    RM_ZERO      = 2'h3
  } fpcm_rm_type;

  typedef enum logic [3:0] {
    OP_MOV    = 4'h0,
    OP_ADD    = 4'h1,
    OP_MUL    = 4'h2,
    OP_MAC    = 4'h3,
    OP_MACA   = 4'h4,
    OP_ACCW   = 4'h5,
    OP_MIN    = 4'h6,
    OP_MAX    = 4'h7,
    OP_CMP_LT = 4'h8,
    OP_CMP_GE = 4'h9,
    OP_RCP    = 4'hA,
    OP_DIV    = 4'hB
  } fpcm_op_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_EXEC = 4'h2,
    ST_ADD  = 4'h4,
    ST_RCP  = 4'h8
  } fpcm_state_type;

  // unrounded value: leading one at sig[26], sig[0] is sticky
  typedef struct packed {
    logic               nan;
    logic               inf;
    logic               zero;
    logic               sign;
    logic signed [11:0] exp;
    logic [26:0]        sig;
  } fpcm_num_type;

  typedef struct packed {
    fpcm_state_type state;
    logic           ready;
    logic           done;
    fpcm_op_type    op;
    fpcm_rm_type    rm;
    logic [31:0]    w0;
    logic [31:0]    w1;
    logic [31:0]    w2;
    logic           h0;
    logic           h1;
    logic           h2;
    fpcm_num_type   t;
    fpcm_num_type   acc;
    logic [4:0]     cnt;
    logic [24:0]    rem;
    logic [27:0]    quo;
    logic [31:0]    result;
    logic           flag;
    logic           flag_we;
  } fpcm_regs_type;

  localparam fpcm_regs_type REGS_RESET = '{
    state: ST_IDLE, ready: 1'b1, op: OP_MOV, rm: RM_NEAR_EVEN, default: '0
  };

endpackage

//--- hdl/fpcm_opnd_if.sv
`timescale 1ns/100ps
interface fpcm_opnd_if;
  logic [31:0]        word;
  logic               half;
  logic               sign;
  logic signed [11:0] exp;
  logic [23:0]        sig;
  logic               nan;
  logic               inf;
  logic               zero;
  logic               denorm;

  modport prod (input word, half,
                output sign, exp, sig, nan, inf, zero, denorm);
  modport cons (output word, half,
                input sign, exp, sig, nan, inf, zero, denorm);
endinterface

//--- hdl/fpcm_unpack.sv
`timescale 1ns/100ps
module fpcm_unpack (
  // raw operand in, classified and normalised operand out
  fpcm_opnd_if.prod opnd
);
  import fpcm_pkg::*;

  logic [4:0]  e5;
  logic [7:0]  e8;
  logic [22:0] frac;
  logic [4:0]  lz;
  logic        e_zero;
  logic        e_ones;

  // half inputs are widened exactly; denormals of either width come out
  // as normal values with a small or negative exponent
  always_comb begin
    e5 = opnd.word[14:10];
    e8 = opnd.word[30:23];
    frac = opnd.half ? {opnd.word[9:0], 13'h0000} : opnd.word[22:0];
    e_zero = opnd.half ? (e5 == 5'h00) : (e8 == 8'h00);
    e_ones = opnd.half ? (e5 == 5'h1F) : (e8 == EXP_ALL_ONES);
    lz = 5'h00;
    for (int i = 0; i < 23; i++) begin
      if (frac[i]) begin
        lz = 5'(22 - i);
      end
    end
    opnd.sign = opnd.half ? opnd.word[HLF_SGN_POS] : opnd.word[SGN_POS];
    opnd.nan = e_ones & (frac != 23'h000000);
    opnd.inf = e_ones & (frac == 23'h000000);
    opnd.zero = e_zero & (frac == 23'h000000);
    opnd.denorm = e_zero & (frac != 23'h000000);
    if (e_ones) begin
      opnd.exp = EXP_SPECIAL;
      opnd.sig = {1'b1, frac};
    end else if (opnd.zero) begin
      opnd.exp = 12'h000;
      opnd.sig = 24'h000000;
    end else if (opnd.denorm) begin
      // normalise: further on only the compare network treats them specially, as zero
      opnd.exp = (opnd.half ? HLF_REBIAS : 12'h000) - 12'(lz);
      opnd.sig = {frac, 1'b0} << lz;
    end else begin
      opnd.exp = opnd.half ? 12'(e5) + HLF_REBIAS : 12'(e8);
      opnd.sig = {1'b1, frac};
    end
  end

endmodule

//--- testbench/fpcm_checker.sv
`timescale 1ns/100ps
module fpcm_checker (
  // clock and reset
  input wire logic                  clk_sys,
  input wire logic                  arst_n,
  // issue side
  input wire logic                  issue_valid,
  input wire fpcm_pkg::fpcm_op_type issue_op,
  input wire logic                  issue_ready,
  // result side
  input wire logic                  result_valid,
  input wire logic [31:0]           result_data,
  input wire logic                  flag_data,
  input wire logic                  flag_write
);
  import fpcm_pkg::*;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  logic take;
  logic is_cmp;
  logic is_mm;

  // only a taken request starts work; a refused one must leave no trace
  assign take   = issue_valid && issue_ready;
  assign is_cmp = issue_op inside {OP_CMP_LT, OP_CMP_GE};
  assign is_mm  = issue_op inside {OP_MIN, OP_MAX};

  a_cmp_flag_pulse: assert property (
    take && is_cmp |-> ##[1:3] (flag_write && result_valid))
    else $error("compare gave no flag pulse");
  a_flag_with_result: assert property (
    flag_write |-> result_valid)
    else $error("flag pulse without a result");
  a_cmp_word_matches: assert property (
    flag_write |-> result_data == {32{flag_data}})
    else $error("compare word disagrees with flag");
  a_minmax_no_flag: assert property (
    take && is_mm |-> !flag_write [*4])
    else $error("min or max wrote the flag");
  a_flag_only_cmp: assert property (
    $changed(flag_data) |-> flag_write)
    else $error("flag moved without a compare");
  a_word_on_result: assert property (
    $changed(result_data) |-> result_valid)
    else $error("result word moved without completion");
  a_move_answers: assert property (
    take && issue_op == OP_MOV |-> ##[1:3] result_valid)
    else $error("move gave no answer in time");
  a_div_two_step: assert property (
    take && issue_op == OP_DIV |=> !result_valid [*8] ##[20:25] result_valid)
    else $error("divide latency out of range");
  a_pulse_single: assert property (
    result_valid |=> !result_valid)
    else $error("result pulse longer than one cycle");
endmodule

//--- testbench/fpcm_issue_model.sv
`timescale 1ns/100ps
module fpcm_issue_model (
  // clock and handshake
  input  wire logic             clk_sys,
  input  wire logic             issue_ready,
  // request to the datapath
  output logic                  issue_valid,
  output fpcm_pkg::fpcm_op_type issue_op,
  output fpcm_pkg::fpcm_rm_type rounding_mode,
  output logic [31:0]           src0_data,
  output logic [31:0]           src1_data,
  output logic [31:0]           src2_data,
  output logic [2:0]            src_half
);
  import fpcm_pkg::*;

  // idle request at time zero
  initial begin
    issue_valid   = 1'b0;
    issue_op      = OP_MOV;
    rounding_mode = RM_NEAR_EVEN;
    src0_data     = 32'h0;
    src1_data     = 32'h0;
    src2_data     = 32'h0;
    src_half      = 3'h0;
  end

  // the request is held until the edge that takes it; then the operand
  // lines are inverted so a stale value never passes for a fresh one
  task automatic send(input fpcm_op_type op, input fpcm_rm_type rm,
                      input logic [31:0] a, input logic [31:0] b,
                      input logic [31:0] c, input logic [2:0] h);
    @(negedge clk_sys);
    issue_valid   = 1'b1;
    issue_op      = op;
    rounding_mode = rm;
    src0_data     = a;
    src1_data     = b;
    src2_data     = c;
    src_half      = h;
    while (issue_ready !== 1'b1) begin
      @(negedge clk_sys);
    end
    @(negedge clk_sys);
    issue_valid = 1'b0;
    src0_data   = ~a;
    src1_data   = ~b;
    src2_data   = ~c;
  endtask
endmodule

//--- testbench/test_fpcm_top.sv
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
  begin \
    cmp_count++; \
    if ((gt) !== (ex)) begin \
      err_total++; \
      $display("[FAIL] %s expected %h seen %h", nm, ex, gt); \
    end \
  end

module test_fpcm_top;
  import fpcm_pkg::*;

  typedef struct {
    fpcm_op_type op;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [2:0]  h;
    logic [31:0] e;
  } fpcm_case_type;

  logic                  clk_sys;
  logic                  arst_n;
  logic                  issue_valid;
  fpcm_op_type           issue_op;
  fpcm_rm_type           rounding_mode;
  logic [31:0]           src0_data;
  logic [31:0]           src1_data;
  logic [31:0]           src2_data;
  logic [2:0]            src_half;
  logic                  issue_ready;
  logic                  result_valid;
  logic [31:0]           result_data;
  logic                  flag_data;
  logic                  flag_write;
  int                    err_total = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;

  fpcm_top fpcm_top_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .issue_valid(issue_valid),
    .issue_op(issue_op), .rounding_mode(rounding_mode),
    .src0_data(src0_data), .src1_data(src1_data), .src2_data(src2_data),
    .src0_half(src_half[0]), .src1_half(src_half[1]),
    .src2_half(src_half[2]), .issue_ready(issue_ready),
    .result_valid(result_valid), .result_data(result_data),
    .flag_data(flag_data), .flag_write(flag_write));

  fpcm_issue_model fpcm_issue_model_inst (
    .clk_sys(clk_sys), .issue_ready(issue_ready),
    .issue_valid(issue_valid), .issue_op(issue_op),
    .rounding_mode(rounding_mode), .src0_data(src0_data),
    .src1_data(src1_data), .src2_data(src2_data), .src_half(src_half));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // the whole run needs about 650 cycles; a hang is cut off well after
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // issue one operation and stop at the falling edge showing its result
  task automatic run(input fpcm_op_type op, input fpcm_rm_type rm,
                     input logic [31:0] a, input logic [31:0] b,
                     input logic [31:0] c, input logic [2:0] h);
    int n;
    fpcm_issue_model_inst.send(op, rm, a, b, c, h);
    n = 0;
    while (result_valid !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK("answer in time", 2'h3, {issue_ready, result_valid})
  endtask

  task automatic test_compare_table();
    logic [31:0] v [9] = '{32'hFF80_0000, 32'hBF80_0000, 32'h8000_0001,
      32'h8000_0000, 32'h0000_0000, 32'h0000_0001, 32'h3F80_0000,
      32'h7F80_0000, 32'h7FC0_0001};
    int rk [9] = '{0, 1, 2, 2, 2, 2, 3, 4, 9};
    logic ord;
    logic nb;
    logic na;
    for (int i = 0; i < 9; i++) begin
      for (int j = 0; j < 9; j++) begin
        // negative zero ranks below positive zero, denormals sit with both
        ord = rk[i] < rk[j] || (i == 3 && j == 4);
        nb = j == 8;
        na = i == 8;
        run(OP_CMP_LT, RM_NEAR_EVEN, v[i], v[j], 32'h0, 3'h0);
        `CHK("lt flag", nb || (!na && ord), flag_data)
        `CHK("lt word", {32{nb || (!na && ord)}}, result_data)
        run(OP_CMP_GE, RM_NEAR_EVEN, v[i], v[j], 32'h0, 3'h0);
        `CHK("ge flag", nb || (!na && !ord), flag_data)
        `CHK("ge pulse", 1'b1, flag_write)
      end
    end
    $display("compare table done");
  endtask

  task automatic test_min_max();
    logic [31:0] a [8] = '{32'h7FC0_0001, 32'h4000_0000, 32'h7FC0_0003,
      32'h7FC0_0003, 32'h3F80_0000, 32'h3F80_0000, 32'h8000_0000,
      32'h8000_0000};
    logic [31:0] b [8] = '{32'h4000_0000, 32'h7FC0_0001, 32'hFFC0_0002,
      32'hFFC0_0002, 32'h4000_0000, 32'h4000_0000, 32'h0000_0000,
      32'h0000_0000};
    logic [31:0] e [8] = '{32'h4000_0000, 32'h4000_0000, 32'hFFC0_0002,
      32'hFFC0_0002, 32'h3F80_0000, 32'h4000_0000, 32'h8000_0000,
      32'h0000_0000};
    for (int i = 0; i < 8; i++) begin
      run(i[0] ? OP_MAX : OP_MIN, RM_NEAR_EVEN, a[i], b[i], 32'h0, 3'h0);
      `CHK("min max", e[i], result_data)
      `CHK("no flag", 1'b0, flag_write)
    end
    $display("min max test done");
  endtask

  task automatic test_rounding();
    logic [31:0] a [3] = '{32'h3F80_0000, 32'hBF80_0000, 32'h3F80_0000};
    logic [31:0] b [3] = '{32'h3380_0000, 32'hB380_0000, 32'h3440_0000};
    logic [31:0] e [3][4] = '{
      '{32'h3F80_0000, 32'h3F80_0001, 32'h3F80_0000, 32'h3F80_0000},
      '{32'hBF80_0000, 32'hBF80_0000, 32'hBF80_0001, 32'hBF80_0000},
      '{32'h3F80_0002, 32'h3F80_0002, 32'h3F80_0001, 32'h3F80_0001}};
    for (int i = 0; i < 3; i++) begin
      for (int m = 0; m < 4; m++) begin
        run(OP_ADD, fpcm_rm_type'(m), a[i], b[i], 32'h0, 3'h0);
        `CHK("rounded sum", e[i][m], result_data)
      end
    end
    $display("rounding test done");
  endtask

  task automatic test_identities();
    fpcm_case_type t [13] = '{
      '{OP_MOV, 32'h7F80_0001, 32'h0, 32'h0, 3'h0, 32'h7F80_0001},
      '{OP_MUL, 32'h4049_0FDB, 32'h3F80_0000, 32'h0, 3'h0, 32'h4049_0FDB},
      '{OP_ADD, 32'h4049_0FDB, 32'h0, 32'h0, 3'h0, 32'h4049_0FDB},
      '{OP_ADD, 32'h8000_0000, 32'h0, 32'h0, 3'h0, 32'h0},
      '{OP_MUL, 32'h1, 32'h3F80_0000, 32'h0, 3'h1, 32'h3380_0000},
      '{OP_MUL, 32'h1, 32'h0880_0000, 32'h0, 3'h1, 32'h0000_8000},
      '{OP_ADD, 32'h3C00, 32'h3F80_0000, 32'h0, 3'h1, 32'h4000_0000},
      '{OP_DIV, 32'h3F80_0000, 32'h4040_0000, 32'h0, 3'h0, 32'h3EAA_AAAB},
      '{OP_RCP, 32'h0, 32'h4040_0000, 32'h0, 3'h0, 32'h3EAA_AAAB},
      '{OP_MAC, 32'h5F80_0000, 32'h5F80_0000, 32'hFF7F_FFFF, 3'h0,
        32'h7380_0000},
      '{OP_MAC, 32'h4000_0000, 32'h4040_0000, 32'h3F80_0000, 3'h0,
        32'h40E0_0000},
      '{OP_ACCW, 32'h3F80_0000, 32'h0, 32'h0, 3'h0, 32'h3F80_0000},
      '{OP_MACA, 32'h4000_0000, 32'h4040_0000, 32'h0, 3'h0, 32'h40E0_0000}};
    for (int i = 0; i < 13; i++) begin
      run(t[i].op, RM_NEAR_EVEN, t[i].a, t[i].b, t[i].c, t[i].h);
      `CHK("identity", t[i].e, result_data)
    end
    run(OP_ADD, RM_NEAR_EVEN, 32'h7FC0_0001, 32'h3F80_0000, 32'h0, 3'h0);
    `CHK("nan out", 1'b1, result_data[30:23] == 8'hFF)
    `CHK("nan frac", 1'b1, result_data[22:0] != 23'h0)
    $display("identity test done");
  endtask

  // hold reset two cycles, release away from the rising edge
  initial begin
    arst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    test_compare_table();
    test_min_max();
    test_rounding();
    test_identities();
    conclude();
  end
endmodule

bind fpcm_top fpcm_checker fpcm_checker_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .issue_valid(issue_valid),
  .issue_op(issue_op), .issue_ready(issue_ready),
  .result_valid(result_valid), .result_data(result_data),
  .flag_data(flag_data), .flag_write(flag_write));
